// file: verilog/fmsc_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the fan monitor status and configuration bank.
// Assumes it is included by bare name, once per compilation unit.
//
// Notes on behaviour
// - Config bit 6 selects two or four pulses
// - Fast bit: speed refresh 250ms, else 1s
// - Config bit 4 enables overtemp pin, else Hi-Z
// - Reserved: bit 3 reads one, 2:0 zero
// - Status read clears the clearable flags
// - Flags sticky until read, whether or not condition gone
// - Local flags re-set next monitoring cycle if persisting
// - Bit 7 set at or below local low
// - Bit 6 set at or above local high
// - Sensor fault: bit 5, overtemp pin, -128 data
// - Fault flag raises alert when enabled
// - Fault flag held until reset, read ignores
// - Bit 4 above remote limit, drives critical pin
// - Critical flag raises alert when enabled
// - Critical flag rearms 5 degrees below limit
// - Reset: status 0x00, config 0x08
`ifndef FMSC_REGS_SVH
`define FMSC_REGS_SVH

// Register offsets
`define FMSC_ADDR_ALARM_STATUS_ONE 8'h02
`define FMSC_ADDR_FAN_SPEED_COUNT_PIN_CONFIG 8'h04

// Reset values
`define FMSC_RST_ALARM_STATUS_ONE 8'h00
`define FMSC_RST_FAN_SPEED_COUNT_PIN_CONFIG 8'h08

// Alarm status field positions
`define FMSC_BIT_LOCAL_LOW 7
`define FMSC_BIT_LOCAL_HIGH 6
`define FMSC_BIT_SENSOR_FAIL 5
`define FMSC_BIT_REMOTE_CRIT 4

// Configuration field positions
`define FMSC_BIT_MODE_REQ 7
`define FMSC_BIT_PULSES_PER_REV 6
`define FMSC_BIT_FAST_UPDATE 5
`define FMSC_BIT_OVERTEMP_EN 4

// Reserved low nibble of the configuration register
`define FMSC_CFG_RSVD_VALUE 4'h8

// Forced remote reading on a failed sensor, -128 degrees
`define FMSC_FAIL_TEMP 8'h80

// Hysteresis before the critical flag rearms, degrees
`define FMSC_CRIT_HYST_DEG 9'sd5

// Clock rate and speed refresh periods
`define FMSC_CLK_HZ 20000000
`define FMSC_FAST_MS 250
`define FMSC_SLOW_MS 1000
`define FMSC_FAST_CYCLES ((`FMSC_CLK_HZ / 1000) * `FMSC_FAST_MS)
`define FMSC_SLOW_CYCLES ((`FMSC_CLK_HZ / 1000) * `FMSC_SLOW_MS)

`endif

// file: verilog/fmsc_pkg.sv
// Types shared by the fan monitor status and configuration bank.
// Assumes fmsc_regs.svh carries all numeric constants.
package fmsc_pkg;

	// One register byte
	typedef logic [7:0] fmsc_byte_t;

	// Temperature in whole degrees, two's complement
	typedef logic signed [7:0] fmsc_temp_t;

	// Refresh counter, wide enough for one second at 20 MHz
	typedef logic [24:0] fmsc_refresh_cnt_t;

endpackage

// file: verilog/fmsc_top.sv
// Alarm status one and tachometer/pin configuration registers of a
// temperature monitor, with their flag, pin and refresh logic.
// Assumes the serial bus engine, the converters and the limit
// registers sit on the same clock and hand us single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "fmsc_regs.svh"

module fmsc_top
	import fmsc_pkg::*;
#(
	// Speed refresh periods in clock cycles, shortenable for simulation
	parameter int FAST_CYCLES = `FMSC_FAST_CYCLES,
	parameter int SLOW_CYCLES = `FMSC_SLOW_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	input wire logic soft_reset,

	// Register access from the bus engine
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,

	// Monitoring results from the conversion logic
	input wire logic monitor_tick,
	input wire logic signed [7:0] local_temp,
	input wire logic signed [7:0] remote_temp,
	input wire logic remote_sensor_fault,

	// Limits and interrupt enables from neighbouring registers
	input wire logic signed [7:0] local_low_limit,
	input wire logic signed [7:0] local_high_limit,
	input wire logic signed [7:0] remote_crit_limit,
	input wire logic sensor_fail_irq_enable,
	input wire logic critical_irq_enable,

	// Fan speed measurement
	input wire logic [15:0] fan_raw_count,
	output logic [15:0] fan_speed_count,
	output logic fan_speed_refresh,
	output logic pulses_per_rev_select,

	// Remote temperature data as seen by software
	output logic [7:0] remote_temp_data,

	// Open-drain style pins: output level and enable
	output logic alert_n_o,
	output logic alert_n_oe,
	output logic critical_temp_pin_n_o,
	output logic critical_temp_pin_n_oe,
	output logic overtemp_pin_n_o,
	output logic overtemp_pin_n_oe
);

	// Address hits, decoded once
	logic hit_status; // Alarm status one selected
	logic hit_config; // Fan_speed_count/pin config selected
	logic status_read; // Clearing read of alarm status one
	logic config_write; // Software write to config

	// Configuration storage, upper writable nibble only
	logic [3:0] cfg_r;

	// Alarm flags
	logic local_low_flag_r;
	logic local_high_flag_r;
	logic remote_sensor_fail_flag_r;
	logic remote_critical_flag_r;
	logic crit_armed_r; // Critical flag may set again

	// Conditions seen on a monitoring cycle
	logic local_low_cond;
	logic local_high_cond;
	logic remote_crit_cond;
	logic remote_rearm_cond;
	logic signed [8:0] rearm_level;

	// Assembled register views
	fmsc_byte_t status_view;
	fmsc_byte_t config_view;

	// Speed refresh timer
	fmsc_refresh_cnt_t refresh_cnt_r;
	fmsc_refresh_cnt_t refresh_last;
	logic refresh_hit;

	// Pin drive levels
	logic alert_assert;
	logic overtemp_assert;

	// Address decoding, plain compare of the byte address
	always_comb begin
		hit_status = 1'b0;
		hit_config = 1'b0;
		if (reg_addr == `FMSC_ADDR_ALARM_STATUS_ONE) begin
			hit_status = 1'b1;
		end else if (reg_addr == `FMSC_ADDR_FAN_SPEED_COUNT_PIN_CONFIG) begin
			hit_config = 1'b1;
		end
	end

	assign status_read = reg_rd & hit_status;
	assign config_write = reg_wr & hit_config;

	// Limit comparisons, signed whole degrees
	assign local_low_cond = (local_temp <= local_low_limit);
	assign local_high_cond = (local_temp >= local_high_limit);
	assign remote_crit_cond = (remote_temp > remote_crit_limit);

	// Rearm level, widened so a limit near -128 cannot wrap
	assign rearm_level = 9'($signed({remote_crit_limit[7], remote_crit_limit}))
		- `FMSC_CRIT_HYST_DEG;
	assign remote_rearm_cond =
		($signed({remote_temp[7], remote_temp}) <= rearm_level);

	// Configuration register; low nibble is never stored
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			// Upper nibble of the reset byte, cut to the stored width
			cfg_r <= 4'(`FMSC_RST_FAN_SPEED_COUNT_PIN_CONFIG >> 4);
		end else if (soft_reset) begin
			cfg_r <= 4'(`FMSC_RST_FAN_SPEED_COUNT_PIN_CONFIG >> 4);
		end else if (config_write) begin
			// Only bits 7:4 land; reserved writes are dropped
			cfg_r <= reg_wdata[7:4];
		end
	end

	// Config readback with the fixed reserved nibble
	assign config_view = {cfg_r, `FMSC_CFG_RSVD_VALUE};

	// Decoded configuration fields; bit 7 is only stored, the
	// host is expected to program it to one
	assign pulses_per_rev_select = config_view[`FMSC_BIT_PULSES_PER_REV];

	// Local low flag: set on a monitoring cycle, cleared by read
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			local_low_flag_r <= 1'b0;
		end else if (soft_reset) begin
			local_low_flag_r <= 1'b0;
		end else if (monitor_tick && local_low_cond) begin
			// Set beats a read in the same cycle
			local_low_flag_r <= 1'b1;
		end else if (status_read) begin
			local_low_flag_r <= 1'b0;
		end
	end

	// Local high flag, same sticky behaviour
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			local_high_flag_r <= 1'b0;
		end else if (soft_reset) begin
			local_high_flag_r <= 1'b0;
		end else if (monitor_tick && local_high_cond) begin
			local_high_flag_r <= 1'b1;
		end else if (status_read) begin
			local_high_flag_r <= 1'b0;
		end
	end

	// Sensor failure flag: reads never clear it, only resets do
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			remote_sensor_fail_flag_r <= 1'b0;
		end else if (soft_reset) begin
			remote_sensor_fail_flag_r <= 1'b0;
		end else if (remote_sensor_fault) begin
			// Caught at once, not on the monitoring cycle
			remote_sensor_fail_flag_r <= 1'b1;
		end
	end

	// Remote critical flag; a clearing read disarms it until the
	// remote reading is at or below the hysteresis level on a monitoring cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			remote_critical_flag_r <= 1'b0;
		end else if (soft_reset) begin
			remote_critical_flag_r <= 1'b0;
		end else if (monitor_tick && remote_crit_cond && crit_armed_r) begin
			remote_critical_flag_r <= 1'b1;
		end else if (status_read) begin
			remote_critical_flag_r <= 1'b0;
		end
	end

	// Rearm tracking for the critical flag
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			crit_armed_r <= 1'b1;
		end else if (soft_reset) begin
			crit_armed_r <= 1'b1;
		end else if (monitor_tick && remote_rearm_cond) begin
			// Cooled far enough; a fresh excursion may set again
			crit_armed_r <= 1'b1;
		end else if (status_read && remote_critical_flag_r &&
			!(monitor_tick && remote_crit_cond && crit_armed_r)) begin
			// Disarm only when the read really clears the flag
			crit_armed_r <= 1'b0;
		end
	end

	// Status readback; unused low bits belong to other logic
	always_comb begin
		status_view = `FMSC_RST_ALARM_STATUS_ONE;
		status_view[`FMSC_BIT_LOCAL_LOW] = local_low_flag_r;
		status_view[`FMSC_BIT_LOCAL_HIGH] = local_high_flag_r;
		status_view[`FMSC_BIT_SENSOR_FAIL] = remote_sensor_fail_flag_r;
		status_view[`FMSC_BIT_REMOTE_CRIT] = remote_critical_flag_r;
	end

	// Read data register; captures the value before any clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (hit_status) begin
				reg_rdata <= status_view;
			end else if (hit_config) begin
				reg_rdata <= config_view;
			end else begin
				// Unmapped here: answer zero
				reg_rdata <= 8'h00;
			end
		end
	end

	// Remote data, forced to -128 while the sensor has failed
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			remote_temp_data <= 8'h00;
		end else if (remote_sensor_fail_flag_r || remote_sensor_fault) begin
			remote_temp_data <= `FMSC_FAIL_TEMP;
		end else if (monitor_tick) begin
			remote_temp_data <= remote_temp;
		end
	end

	// Refresh period follows the fast bit; a mode change takes effect at
	// once, and a count already at or past the new end restarts on the next edge
	assign refresh_last = config_view[`FMSC_BIT_FAST_UPDATE] ?
		fmsc_refresh_cnt_t'(FAST_CYCLES - 1) :
		fmsc_refresh_cnt_t'(SLOW_CYCLES - 1);
	assign refresh_hit = (refresh_cnt_r >= refresh_last);

	// Free-running refresh divider
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			refresh_cnt_r <= '0;
		end else if (refresh_hit || soft_reset) begin
			refresh_cnt_r <= '0;
		end else begin
			refresh_cnt_r <= refresh_cnt_r + 25'h000_0001;
		end
	end

	// One-cycle refresh strobe and latched speed reading
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fan_speed_refresh <= 1'b0;
			fan_speed_count <= 16'h0000;
		end else begin
			fan_speed_refresh <= refresh_hit && !soft_reset;
			if (refresh_hit && !soft_reset) begin
				fan_speed_count <= fan_raw_count;
			end
		end
	end

	// Alert pulled low for either enabled alarm source
	assign alert_assert = (remote_sensor_fail_flag_r && sensor_fail_irq_enable)
		|| (remote_critical_flag_r && critical_irq_enable);

	// Overtemp pin asserted on sensor failure or critical excursion
	assign overtemp_assert = remote_sensor_fail_flag_r || remote_critical_flag_r;

	// Pin drivers, registered so they never glitch
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			alert_n_oe <= 1'b0;
			critical_temp_pin_n_oe <= 1'b0;
			overtemp_pin_n_oe <= 1'b0;
		end else begin
			alert_n_oe <= alert_assert;
			critical_temp_pin_n_oe <= remote_critical_flag_r;
			// Disabled pin floats whatever the alarm state
			overtemp_pin_n_oe <= config_view[`FMSC_BIT_OVERTEMP_EN]
				&& overtemp_assert;
		end
	end

	// Open-drain pins only ever drive low
	assign alert_n_o = 1'b0;
	assign critical_temp_pin_n_o = 1'b0;
	assign overtemp_pin_n_o = 1'b0;

endmodule
`default_nettype wire

// file: tb/fmsc_host.sv
// Bus host model: single byte reads and writes over the strobe port.
// Assumes it shares the bank's clock; strobes move after rising edges.
`timescale 1ns/1ps
`default_nettype none
module fmsc_host (
	// Clock and returned data
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	// Strobe port towards the bank
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'hff;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One write; config writes always carry the mode bit
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= (a == 8'h04) ? (v | 8'h80) : v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~v; // Released lines must not look held
		#1;
	endtask
	// One read; data is taken once the strobe edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// file: tb/fmsc_top_chk.sv
// Checker for the status and config bank, bound to fmsc_top.
// Assumes single clock domain and single-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none
module fmsc_top_chk #(
	parameter int FAST_CYCLES = 8,
	parameter int SLOW_CYCLES = 32
) (
	// Clock and resets
	input wire logic clock,
	input wire logic rstn,
	input wire logic soft_reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Monitoring inputs
	input wire logic monitor_tick,
	input wire logic remote_sensor_fault,
	input wire logic sensor_fail_irq_enable,
	input wire logic critical_irq_enable,
	// Watched outputs
	input wire logic fan_speed_refresh,
	input wire logic pulses_per_rev_select,
	input wire logic [7:0] remote_temp_data,
	input wire logic alert_n_oe,
	input wire logic critical_temp_pin_n_oe,
	input wire logic overtemp_pin_n_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic ot_en_r; // Shadow of the pin enable bit
	logic fail_r; // Shadow of the sticky fail flag
	int gap_r; // Cycles since last refresh pulse
	// Shadow pin enable, cleared by either reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			ot_en_r <= 1'b0;
		else if (soft_reset)
			ot_en_r <= 1'b0;
		else if (reg_wr && reg_addr == 8'h04)
			ot_en_r <= reg_wdata[4];
	end
	// Fail shadow; only a reset drops it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			fail_r <= 1'b0;
		else if (soft_reset)
			fail_r <= 1'b0;
		else if (remote_sensor_fault)
			fail_r <= 1'b1;
	end
	// Refresh spacing counter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			gap_r <= 0;
		else if (fan_speed_refresh)
			gap_r <= 0;
		else
			gap_r <= gap_r + 1;
	end
	// Soft reset, one quiet cycle, then a status read
	sequence s_sr_read;
		soft_reset ##1 (!remote_sensor_fault && !monitor_tick)
			##1 (reg_rd && reg_addr == 8'h02 && !remote_sensor_fault);
	endsequence
	chk_cfg_reserved: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[3:0] == 4'h8)
		else $error("config low nibble wrong");
	chk_pulses_sel: assert property (reg_wr && reg_addr == 8'h04
		|=> pulses_per_rev_select == $past(reg_wdata[6]))
		else $error("pulse select not following config");
	chk_refresh_gap: assert property (fan_speed_refresh |-> gap_r >= FAST_CYCLES - 1)
		else $error("refresh pulses too close");
	chk_overtemp_gate: assert property (overtemp_pin_n_oe |-> ot_en_r || $past(ot_en_r))
		else $error("overtemp pin driven while disabled");
	chk_fail_data: assert property (remote_sensor_fault |=> remote_temp_data == 8'h80)
		else $error("remote data not forced on fault");
	chk_fail_kept: assert property (reg_rd && reg_addr == 8'h02 && fail_r |=> reg_rdata[5])
		else $error("fail flag lost");
	chk_crit_pin: assert property ($rose(critical_temp_pin_n_oe) |-> $past(monitor_tick, 2))
		else $error("critical pin rose without a tick");
	chk_alert_gate: assert property (alert_n_oe
		|-> $past(sensor_fail_irq_enable || critical_irq_enable))
		else $error("alert without enable");
	chk_status_reset: assert property (s_sr_read |=> reg_rdata == 8'h00)
		else $error("status not cleared by soft reset");
endmodule
bind fmsc_top fmsc_top_chk #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) fmsc_top_chk_i (
	.clock, .rstn, .soft_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.monitor_tick, .remote_sensor_fault, .sensor_fail_irq_enable, .critical_irq_enable,
	.fan_speed_refresh, .pulses_per_rev_select, .remote_temp_data, .alert_n_oe,
	.critical_temp_pin_n_oe, .overtemp_pin_n_oe);
`default_nettype wire

// file: tb/tb.sv
// Testbench for the status and config bank, host model on the port.
// Assumes shortened refresh periods of 8 and 32 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
	// Stimulus
	logic clock = 0;
	logic rstn = 0;
	logic soft_reset = 0;
	logic monitor_tick = 0;
	logic remote_sensor_fault = 0;
	logic sensor_fail_irq_enable = 0;
	logic critical_irq_enable = 0;
	logic signed [7:0] local_temp = 0, remote_temp = 0;
	logic signed [7:0] local_low_limit = 0, local_high_limit = 0, remote_crit_limit = 0;
	logic [15:0] fan_raw_count = 16'h1234;
	// Bank outputs and bus lines
	logic [7:0] reg_addr, reg_wdata, reg_rdata, remote_temp_data, d;
	logic reg_wr, reg_rd, fan_speed_refresh, pulses_per_rev_select;
	logic [15:0] fan_speed_count;
	logic alert_n_o, alert_n_oe, critical_temp_pin_n_o, critical_temp_pin_n_oe;
	logic overtemp_pin_n_o, overtemp_pin_n_oe;
	// Pin levels; pull-ups when released
	wire logic alert_n = alert_n_oe ? alert_n_o : 1'b1;
	wire logic crit_n = critical_temp_pin_n_oe ? critical_temp_pin_n_o : 1'b1;
	wire logic ot_n = overtemp_pin_n_oe ? overtemp_pin_n_o : 1'b1;
	int n, failures = 0, n_tests = 0;
	always #25 clock = ~clock;
	fmsc_top #(.FAST_CYCLES(8), .SLOW_CYCLES(32)) fmsc_top_i (.clock, .rstn, .soft_reset,
		.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .monitor_tick, .local_temp,
		.remote_temp, .remote_sensor_fault, .local_low_limit, .local_high_limit,
		.remote_crit_limit, .sensor_fail_irq_enable, .critical_irq_enable, .fan_raw_count,
		.fan_speed_count, .fan_speed_refresh, .pulses_per_rev_select, .remote_temp_data,
		.alert_n_o, .alert_n_oe, .critical_temp_pin_n_o, .critical_temp_pin_n_oe,
		.overtemp_pin_n_o, .overtemp_pin_n_oe);
	fmsc_host fmsc_host_i (.clock, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
	// Value compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One monitoring cycle, then wait for the pins
	task automatic tk();
		@(posedge clock);
		monitor_tick <= 1'b1;
		@(posedge clock);
		monitor_tick <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	// Cycles from one refresh pulse to the next, bounded
	task automatic gap(output int k);
		k = 0;
		while (fan_speed_refresh !== 1'b1 && k < 100) begin
			@(posedge clock);
			#1;
			k++;
		end
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (fan_speed_refresh !== 1'b1 && k < 100);
	endtask
	// Counts and verdict
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog, far beyond the expected few hundred cycles
	initial begin
		#300000;
		failures++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h00);
		fmsc_host_i.rd(8'h04, d); chk(d, 8'h08);
		fmsc_host_i.rd(8'h10, d); chk(d, 8'h00);
		fmsc_host_i.wr(8'h04, 8'hf7); chk(pulses_per_rev_select, 1);
		fmsc_host_i.rd(8'h04, d); chk(d, 8'hf8);
		fmsc_host_i.wr(8'h04, 8'ha0); chk(pulses_per_rev_select, 0);
		gap(n); gap(n); chk(n, 8);
		chk(fan_speed_count, 16'h1234);
		fmsc_host_i.wr(8'h04, 8'h80); gap(n); gap(n); chk(n, 32);
		local_low_limit <= 8'sd10; local_high_limit <= 8'sd30; local_temp <= 8'sd10;
		tk(); local_temp <= 8'sd20; tk();
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h80);
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h00);
		local_temp <= 8'sd30; tk();
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h40);
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h00);
		tk(); fmsc_host_i.rd(8'h02, d); chk(d, 8'h40);
		fork
			fmsc_host_i.rd(8'h02, d);
			tk();
		join
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h40);
		local_temp <= 8'sd20; fmsc_host_i.rd(8'h02, d);
		remote_crit_limit <= 8'sd50; remote_temp <= 8'sd51; critical_irq_enable <= 1'b1;
		tk(); chk(crit_n, 0); chk(alert_n, 0); chk(ot_n, 1);
		chk(remote_temp_data, 8'h33);
		fmsc_host_i.wr(8'h04, 8'h90); @(posedge clock); #1; chk(ot_n, 0);
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h10);
		tk(); chk(crit_n, 1); fmsc_host_i.rd(8'h02, d); chk(d, 8'h00);
		remote_temp <= 8'sd46; tk(); remote_temp <= 8'sd51; tk();
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h00);
		remote_temp <= 8'sd45; tk(); remote_temp <= 8'sd51; tk();
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h10);
		critical_irq_enable <= 1'b0; sensor_fail_irq_enable <= 1'b1;
		@(posedge clock); remote_sensor_fault <= 1'b1;
		@(posedge clock); remote_sensor_fault <= 1'b0;
		repeat (2) @(posedge clock); #1;
		chk(remote_temp_data, 8'h80); chk(ot_n, 0); chk(alert_n, 0);
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h20);
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h20);
		@(posedge clock); soft_reset <= 1'b1;
		@(posedge clock); soft_reset <= 1'b0;
		fmsc_host_i.rd(8'h02, d); chk(d, 8'h00);
		fmsc_host_i.rd(8'h04, d); chk(d, 8'h08);
		wrap_up();
	end
endmodule
`default_nettype wire
